// File: core/fan_pwm_consts.svh
`ifndef FAN_PWM_CONSTS_SVH
`define FAN_PWM_CONSTS_SVH

// Duty level quantisation
`define DUTY_WIDTH 8
`define DUTY_FULL 8'hFF
// Time base: 30 Hz period at a 20 MHz clock
`define CLK_HZ 20000000
`define TIME_BASE_HZ 30
`define TIME_BASE_CYCLES (`CLK_HZ / `TIME_BASE_HZ)
// Forced-on interval in time-base periods
`define STARTUP_PERIODS 64
// Interrupt status bit positions
`define IRQ_BIT_FAULT 0
`define IRQ_BIT_SLEEP 1
`define IRQ_BIT_WAKE 2
`define IRQ_BIT_SHUTDOWN 3
`define IRQ_WIDTH 4
// Register indices
`define REG_STATUS 4'h0
`define REG_IRQ_STATUS 4'h1
`define REG_IRQ_MASK 4'h2
`define REG_DUTY 4'h3
`define REG_ADDR_WIDTH 4
`define IRQ_MASK_RESET 4'h0

`endif

// File: core/fan_pwm_pkg.sv
package fan_pwm_pkg;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_SLEEP,
    ST_STARTUP,
    ST_NORMAL
  } fan_state_t;

  // Comparator flags from the analog front end
  typedef struct packed {
    logic primary_above_shutdown;
    logic primary_above_restart;
    logic primary_below_sleep;
    logic secondary_below_sleep;
    logic primary_above_wake;
    logic secondary_above_wake;
    logic primary_above_full;
    logic primary_above_overtemp;
  } level_flags_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// File: core/time_base_gen.sv
`timescale 1ns/1ps
`include "fan_pwm_consts.svh"

module time_base_gen #(
  parameter int unsigned PERIOD_CYCLES = `TIME_BASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  output logic tick_o
);

  localparam int unsigned CW = $clog2(PERIOD_CYCLES);
  logic [CW-1:0] count_q;

  initial begin
    if (PERIOD_CYCLES < 2) $error("time base period too short");
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= '0;
      tick_o <= 1'b0;
    end else if (count_q == CW'(PERIOD_CYCLES - 1)) begin
      count_q <= '0;
      tick_o <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule

// File: core/thermal_fan_pwm_controller.sv
`timescale 1ns/1ps
`include "fan_pwm_consts.svh"

module thermal_fan_pwm_controller
  import fan_pwm_pkg::*;
#(
  parameter int unsigned TIME_BASE_CYCLES = `TIME_BASE_CYCLES,
  parameter int unsigned STARTUP_PERIODS = `STARTUP_PERIODS,
  parameter int unsigned DUTY_WIDTH = `DUTY_WIDTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire fan_pwm_pkg::level_flags_t flags_i,
  input wire logic [DUTY_WIDTH-1:0] primary_temp_input_i,
  input wire logic [DUTY_WIDTH-1:0] secondary_control_input_i,
  input wire fan_pwm_pkg::reg_req_t req_i,
  output logic [31:0] rdata_o,
  output logic fan_drive_o,
  output logic fan_drive_oe_o,
  output logic overtemp_fault_n_o,
  output logic overtemp_fault_n_oe_o,
  output logic irq_o
);

  import fan_pwm_pkg::*;

  initial begin
    if (DUTY_WIDTH < 2 || DUTY_WIDTH > 16) $error("duty width unsupported");
    if (STARTUP_PERIODS < 1 || STARTUP_PERIODS > 255) $error("startup periods unsupported");
    // Each duty step needs at least two clocks of the step counter
    if ((TIME_BASE_CYCLES >> DUTY_WIDTH) < 2) $error("time base too short for duty steps");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [DUTY_WIDTH-1:0] max_level(
    input logic [DUTY_WIDTH-1:0] a,
    input logic [DUTY_WIDTH-1:0] b
  );
    max_level = (a >= b) ? a : b;
  endfunction

  // Top of the ramp or of the duty range
  function automatic logic at_top(input logic [DUTY_WIDTH-1:0] v);
    at_top = (v == {DUTY_WIDTH{1'b1}});
  endfunction

  // ==========================================================
  // Shutdown as asynchronous reset, released on the clock
  // ==========================================================
  logic shut_async;
  logic shut_sync1_q;
  logic shut_sync2_q;
  logic core_reset;

  assign shut_async = reset_i | ~flags_i.primary_above_shutdown;

  // Assert at once, release two clean edges later so the core never leaves
  // reset on a glitchy comparator edge.
  always_ff @(posedge clk_i or posedge shut_async) begin
    if (shut_async) begin
      shut_sync1_q <= 1'b1;
      shut_sync2_q <= 1'b1;
    end else begin
      shut_sync1_q <= 1'b0;
      shut_sync2_q <= shut_sync1_q;
    end
  end
  assign core_reset = shut_sync2_q;

  // Restart gate: after shutdown the primary must also pass the restart level
  logic restart_ok_q;
  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      restart_ok_q <= 1'b0;
    end else if (flags_i.primary_above_restart) begin
      restart_ok_q <= 1'b1;
    end
  end

  // ==========================================================
  // Time base and per-period PWM ramp
  // ==========================================================
  logic tick;
  logic [DUTY_WIDTH-1:0] ramp_q;
  localparam int unsigned SUB_CYCLES = (TIME_BASE_CYCLES >> DUTY_WIDTH) < 1 ?
    1 : (TIME_BASE_CYCLES >> DUTY_WIDTH);

  // One time base divided into duty steps: same period for logic and PWM
  time_base_gen #(
    .PERIOD_CYCLES(SUB_CYCLES)
  ) u_time_base (
    .clk_i(clk_i),
    .reset_i(core_reset),
    .tick_o(tick)
  );

  logic period_start;
  assign period_start = tick && at_top(ramp_q);

  // Ramp restarts with the core, so the first period follows shutdown release
  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      ramp_q <= '0;
    end else if (tick) begin
      ramp_q <= ramp_q + 1'b1;
    end
  end

  // ==========================================================
  // Fan state machine
  // ==========================================================
  fan_state_t state_q;
  fan_state_t state_d;
  logic [7:0] startup_cnt_q;
  logic both_below_sleep;
  logic any_above_wake;

  assign both_below_sleep = flags_i.primary_below_sleep & flags_i.secondary_below_sleep;
  assign any_above_wake = flags_i.primary_above_wake | flags_i.secondary_above_wake;

  // Sleep, wake and end of startup all wait for a period boundary
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SHUTDOWN: begin
        // Leaving reset behaves like sleep: wait for a wake crossing
        if (restart_ok_q) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_above_wake && period_start) begin
          state_d = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (period_start && startup_cnt_q == 8'(STARTUP_PERIODS - 1)) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        // A single input low does not sleep the fan
        if (both_below_sleep && period_start) begin
          state_d = ST_SLEEP;
        end
      end
      default: state_d = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      state_q <= ST_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts whole periods; entry always lands on a period boundary
  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      startup_cnt_q <= 8'h00;
    end else if (state_q != ST_STARTUP) begin
      startup_cnt_q <= 8'h00;
    end else if (period_start) begin
      startup_cnt_q <= startup_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Duty selection, latched once per period to avoid runt pulses
  // ==========================================================
  logic [DUTY_WIDTH-1:0] duty_q;
  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      duty_q <= '0;
    end else if (period_start) begin
      if (flags_i.primary_above_full) begin
        duty_q <= {DUTY_WIDTH{1'b1}};
      end else begin
        // Inputs arrive already scaled over the 40 percent span
        // Limitation: no scaling here, the quantiser owns the span
        duty_q <= max_level(primary_temp_input_i, secondary_control_input_i);
      end
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic pwm_on;
  // Full duty bypasses the compare, else the top ramp step would blank
  assign pwm_on = at_top(duty_q) || (ramp_q < duty_q);

  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      fan_drive_o <= 1'b0;
      fan_drive_oe_o <= 1'b1;
    end else begin
      case (state_q)
        ST_STARTUP: begin
          fan_drive_o <= 1'b1;
          fan_drive_oe_o <= 1'b1;
        end
        ST_NORMAL: begin
          fan_drive_o <= pwm_on;
          fan_drive_oe_o <= 1'b1;
        end
        ST_SLEEP: begin
          fan_drive_o <= 1'b0;
          fan_drive_oe_o <= 1'b0;
        end
        default: begin
          fan_drive_o <= 1'b0;
          fan_drive_oe_o <= 1'b1;
        end
      endcase
    end
  end

  // Open-drain fault: low driven while asserted, released otherwise
  // Gated to running states: sleep and shutdown keep it released
  logic fault_active;
  assign fault_active = flags_i.primary_above_overtemp &&
    (state_q == ST_NORMAL || state_q == ST_STARTUP);

  always_ff @(posedge clk_i or posedge core_reset) begin
    if (core_reset) begin
      overtemp_fault_n_o <= 1'b1;
      overtemp_fault_n_oe_o <= 1'b0;
    end else begin
      overtemp_fault_n_o <= ~fault_active;
      overtemp_fault_n_oe_o <= fault_active;
    end
  end

  // ==========================================================
  // Interrupts and registers (survive shutdown, cleared by reset_i)
  // ==========================================================
  logic [`IRQ_WIDTH-1:0] irq_status_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  logic [`IRQ_WIDTH-1:0] irq_event;
  // Edge memories run on reset_i alone, so shutdown entry is seen as an edge
  logic fault_prev_q;
  fan_state_t state_prev_q;
  logic shut_prev_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_prev_q <= 1'b0;
      state_prev_q <= ST_SHUTDOWN;
      shut_prev_q <= 1'b1;
    end else begin
      fault_prev_q <= fault_active;
      state_prev_q <= state_q;
      shut_prev_q <= core_reset;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_BIT_FAULT] = fault_active & ~fault_prev_q;
    irq_event[`IRQ_BIT_SLEEP] = (state_q == ST_SLEEP) && (state_prev_q == ST_NORMAL);
    irq_event[`IRQ_BIT_WAKE] = (state_q == ST_STARTUP) && (state_prev_q == ST_SLEEP);
    irq_event[`IRQ_BIT_SHUTDOWN] = core_reset & ~shut_prev_q;
  end

  // Unmapped writes decode to nothing and are dropped
  logic wr_status;
  logic wr_mask;
  assign wr_status = req_i.wr && (req_i.addr == `REG_IRQ_STATUS);
  assign wr_mask = req_i.wr && (req_i.addr == `REG_IRQ_MASK);

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_status ? req_i.wdata[`IRQ_WIDTH-1:0] : '0))
        | irq_event;
    end
  end

  // Mask resets closed: no interrupt until software opens it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask_q <= `IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= req_i.wdata[`IRQ_WIDTH-1:0];
    end
  end

  // Fresh events included so the line rises with its status bit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_status_q | irq_event) & irq_mask_q);
    end
  end

  // Status word: fault, drive, state, core reset, restart gate
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (req_i.rd) begin
      case (req_i.addr)
        `REG_STATUS: rdata_o <= {26'h0, fault_active, fan_drive_o, state_q, core_reset,
          restart_ok_q};
        `REG_IRQ_STATUS: rdata_o <= {28'h0, irq_status_q};
        `REG_IRQ_MASK: rdata_o <= {28'h0, irq_mask_q};
        `REG_DUTY: rdata_o <= 32'(duty_q);
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// File: verif/fan_sense_model.sv
`timescale 1ns/1ps
module fan_sense_model
  import fan_pwm_pkg::*;
(
  input wire logic [7:0] lvl1_i,
  input wire logic [7:0] lvl2_i,
  output fan_pwm_pkg::level_flags_t flags_o,
  output logic [7:0] duty1_o,
  output logic [7:0] duty2_o
);
  // ==========
  // Levels in percent of supply
  localparam int SHUT = 5, RST = 10, SLP = 25, HYST = 11, LOW = 30, FULL = 70, OT = 77;
  function automatic logic [7:0] to_duty(input logic [7:0] l);
    if (l <= LOW)
      return 8'h00;
    if (l >= FULL)
      return 8'hFF;
    return 8'((int'(l) - LOW) * 255 / (FULL - LOW));
  endfunction
  assign duty1_o = to_duty(lvl1_i);
  assign duty2_o = to_duty(lvl2_i);
  // Overtemperature sits above full duty
  assign flags_o = '{lvl1_i > SHUT, lvl1_i > RST, lvl1_i < SLP, lvl2_i < SLP,
    lvl1_i > SLP + HYST, lvl2_i > SLP + HYST, lvl1_i >= FULL, lvl1_i > OT};
endmodule

// File: verif/thermal_fan_pwm_controller_asserts.sv
`timescale 1ns/1ps
module thermal_fan_pwm_controller_asserts
  import fan_pwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire fan_pwm_pkg::level_flags_t flags_i,
  input wire logic fan_drive_o,
  input wire logic fan_drive_oe_o,
  input wire logic overtemp_fault_n_o,
  input wire logic overtemp_fault_n_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========
  // Pin checks
  a_shut_out: assert property (
    !flags_i.primary_above_shutdown |-> !fan_drive_o && fan_drive_oe_o && overtemp_fault_n_o)
    else $error("fan or fault active in shutdown");
  a_shut_hold: assert property (
    $rose(flags_i.primary_above_shutdown) |-> !fan_drive_o [*2])
    else $error("drive rose before reset release");
  a_fault_oe: assert property (
    !overtemp_fault_n_o |-> overtemp_fault_n_oe_o && fan_drive_oe_o)
    else $error("fault low without enable");
  a_fault_cause: assert property (
    $fell(overtemp_fault_n_o) |-> $past(flags_i.primary_above_overtemp))
    else $error("fault without overtemperature");
  a_fault_clear: assert property (
    !flags_i.primary_above_overtemp [*2] |-> overtemp_fault_n_o)
    else $error("fault held after cooling");
  a_sleep_quiet: assert property (
    !fan_drive_oe_o |-> overtemp_fault_n_o && !overtemp_fault_n_oe_o)
    else $error("fault active in sleep");
  a_sleep_entry: assert property (
    $fell(fan_drive_oe_o) && $past(flags_i.primary_above_shutdown, 8) && !$past(reset_i, 8)
    |-> $past(flags_i.primary_below_sleep && flags_i.secondary_below_sleep, 2))
    else $error("sleep without both inputs low");
  a_wake_start: assert property (
    $rose(fan_drive_oe_o) && flags_i.primary_above_shutdown |-> fan_drive_o [*8])
    else $error("drive not forced high on wake");
endmodule

bind thermal_fan_pwm_controller thermal_fan_pwm_controller_asserts u_chk (.clk_i(clk_i),
  .reset_i(reset_i), .flags_i(flags_i), .fan_drive_o(fan_drive_o),
  .fan_drive_oe_o(fan_drive_oe_o), .overtemp_fault_n_o(overtemp_fault_n_o),
  .overtemp_fault_n_oe_o(overtemp_fault_n_oe_o));

// File: verif/thermal_fan_pwm_controller_bench.sv
`timescale 1ns/1ps
`include "fan_pwm_consts.svh"
module thermal_fan_pwm_controller_bench;
  import fan_pwm_pkg::*;
  // Short time base and startup keep the run brief
  localparam int P = 512;
  localparam int SP = 4;
  logic clk_i = 0, reset_i = 1, rd_p = 0;
  logic [7:0] lvl1 = 8'h14, lvl2 = 8'h0A, d1, d2;
  level_flags_t flags;
  reg_req_t req = '0;
  logic [31:0] rdata_o;
  logic drv, drv_oe, flt_n, flt_oe, irq_o;
  logic [15:0] seed = 16'hC430;
  logic [31:0] q[$];
  int n_errors = 0, n_tests = 0;
  always #25 clk_i = ~clk_i;
  fan_sense_model far (.lvl1_i(lvl1), .lvl2_i(lvl2), .flags_o(flags), .duty1_o(d1),
    .duty2_o(d2));
  thermal_fan_pwm_controller #(.TIME_BASE_CYCLES(P), .STARTUP_PERIODS(SP)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .flags_i(flags), .primary_temp_input_i(d1),
    .secondary_control_input_i(d2), .req_i(req), .rdata_o(rdata_o), .fan_drive_o(drv),
    .fan_drive_oe_o(drv_oe), .overtemp_fault_n_o(flt_n), .overtemp_fault_n_oe_o(flt_oe),
    .irq_o(irq_o));
  // ==========
  // Helpers
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{a, w ? d : 32'h0, w, !w};
    if (!w)
      q.push_back(d);
    @(posedge clk_i);
    req <= '0;
  endtask
  // Order: irq, drive enable, drive, fault, fault enable
  task automatic pins(input logic [4:0] e, input logic [4:0] m);
    @(negedge clk_i);
    cmp({irq_o, drv_oe, drv, flt_n, flt_oe} & m, e);
    @(posedge clk_i);
  endtask
  // High cycles over one whole period
  task automatic duty(input logic [7:0] lv);
    int h;
    logic [7:0] e;
    h = 0;
    e = lv <= 30 ? 8'h00 : lv >= 70 ? 8'hFF : 8'((int'(lv) - 30) * 255 / 40);
    repeat (2 * P) @(posedge clk_i);
    repeat (P) begin
      @(negedge clk_i);
      h += drv;
    end
    cmp(h, e == 8'hFF ? P : e * (P / 256));
  endtask
  always @(posedge clk_i) rd_p <= req.rd;
  always @(negedge clk_i) if (rd_p) cmp(rdata_o, q.pop_front());
  initial begin
    repeat (70 * P) @(posedge clk_i);
    n_errors++;
    results();
  end
  // ==========
  // Scenarios
  initial begin
    logic [7:0] a, b;
    repeat (12) @(posedge clk_i);
    reset_i <= 0;
    repeat (4 * P) @(posedge clk_i);
    pins(5'b00010, 5'h0B);
    bus(1, `REG_IRQ_MASK, 32'hF);
    bus(0, `REG_IRQ_MASK, 32'hF);
    bus(0, 4'h7, 32'h0);
    lvl2 <= 8'h32;
    repeat (2 * P) @(posedge clk_i);
    pins(5'b11110, 5'h1F);
    bus(0, `REG_IRQ_STATUS, 32'h1 << `IRQ_BIT_WAKE);
    bus(1, `REG_IRQ_STATUS, 32'hF);
    bus(0, `REG_IRQ_STATUS, 32'h0);
    pins(5'b01110, 5'h1F);
    repeat (SP * P) @(posedge clk_i);
    $display("test wake and startup done");
    repeat (3) begin
      seed = nx(seed);
      a = 8'(31 + seed % 39);
      seed = nx(seed);
      b = 8'(31 + seed % 39);
      lvl1 <= a;
      lvl2 <= b;
      duty(a > b ? a : b);
    end
    lvl1 <= 8'h4B;
    duty(8'h4B);
    lvl1 <= 8'h50;
    duty(8'h50);
    pins(5'b11101, 5'h1F);
    bus(0, `REG_DUTY, 32'hFF);
    lvl1 <= 8'h3C;
    repeat (4) @(posedge clk_i);
    pins(5'b11010, 5'h1B);
    bus(1, `REG_IRQ_STATUS, 32'hF);
    $display("test duty and fault done");
    lvl1 <= 8'h14;
    lvl2 <= 8'h32;
    duty(8'h32);
    lvl2 <= 8'h0A;
    repeat (2 * P) @(posedge clk_i);
    pins(5'b10010, 5'h1B);
    bus(0, `REG_STATUS, 32'h5);
    lvl1 <= 8'h00;
    lvl2 <= 8'h3C;
    repeat (3) @(posedge clk_i);
    pins(5'b11010, 5'h1F);
    bus(0, `REG_IRQ_STATUS, 32'hA);
    lvl1 <= 8'h14;
    repeat (3 * P) @(posedge clk_i);
    pins(5'b01110, 5'h0F);
    $display("test sleep and shutdown done");
    results();
  end
endmodule
